/* rtl/crs_map.svh */
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// register byte offsets on the avalon slave
`define CRS_OFF_DATA0 8'h00
`define CRS_OFF_DATA1 8'h04
`define CRS_OFF_DATA2 8'h08
`define CRS_OFF_DATA3 8'h0C
`define CRS_OFF_ADDR0 8'h10
`define CRS_OFF_ADDR1 8'h14
`define CRS_OFF_FRAME 8'h18
`define CRS_OFF_VTB 8'h1C
`define CRS_OFF_PC 8'h20
`define CRS_OFF_USP 8'h24
`define CRS_OFF_ISP 8'h28
`define CRS_OFF_SB 8'h2C
`define CRS_OFF_FLAGS 8'h30
`define CRS_OFF_WIDE_D0 8'h34
`define CRS_OFF_WIDE_D1 8'h38
`define CRS_OFF_WIDE_A 8'h3C
`define CRS_OFF_ACT_SP 8'h40
// flag bit positions
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_I 6
`define CRS_FLG_U 7
`define CRS_FLG_IPL_LO 8
`define CRS_FLG_IPL_HI 10
`define CRS_FLG_MASK 11'h7FD
`define CRS_FLG_MASK_LO 8'hFD
`define CRS_FLG_RST 11'h000
`define CRS_PC_RST 20'h00000
`define CRS_SWI_LAST 6'h1F
// memory decode bounds
`define CRS_SFR0_LO 20'h00000
`define CRS_SFR0_HI 20'h002FF
`define CRS_RAM_LO 20'h00400
`define CRS_SFR1_LO 20'h02C00
`define CRS_SFR1_HI 20'h02FFF
`define CRS_DF_LO 20'h03000
`define CRS_DF_HI 20'h03FFF
`define CRS_ROM_LO 20'h04000
`define CRS_VEC_LO 20'h0FFDC
`define CRS_VEC_HI 20'h0FFFF
`define CRS_RAM_HI_DEF 20'h01BFF
`define CRS_ROM_HI_DEF 20'h13FFF
`endif

/* rtl/crs_pkg.sv */
package crs_pkg;
    typedef enum logic [2:0] {
        CRS_REG_NONE = 3'b000,
        CRS_REG_SFR = 3'b001,
        CRS_REG_RAM = 3'b010,
        CRS_REG_DFLASH = 3'b011,
        CRS_REG_ROM = 3'b100,
        CRS_REG_VEC = 3'b101
    } crs_region_e;
    typedef struct packed {
        logic valid;
        logic carry;
        logic zero;
        logic sign;
        logic ovf;
    } crs_alu_flags_s;
    typedef struct packed {
        logic hw_ack;
        logic sw_int;
        logic [5:0] sw_num;
    } crs_int_ack_s;
endpackage

/* rtl/crs_regset.sv */
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"
module crs_regset #(
    parameter logic [19:0] RAM_HI = `CRS_RAM_HI_DEF,
    parameter logic [19:0] ROM_HI = `CRS_ROM_HI_DEF,
    parameter bit HAS_DFLASH = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic pc_load_i,
    input wire logic [19:0] pc_next_i,
    input wire crs_pkg::crs_alu_flags_s alu_flags_i,
    input wire crs_pkg::crs_int_ack_s int_ack_i,
    input wire logic irq_req_i,
    input wire logic [2:0] irq_level_i,
    output logic irq_accept_o,
    input wire logic [19:0] mem_addr_i,
    output crs_pkg::crs_region_e mem_region_o,
    output logic [19:0] pc_o,
    output logic [15:0] active_sp_o,
    output logic bank_sel_o
);
    import crs_pkg::*;

    logic [15:0] data_r [2][4];
    logic [15:0] addr_r [2][2];
    logic [15:0] frame_r [2];
    logic [19:0] vtb_r;
    logic [19:0] pc_r;
    logic [15:0] usp_r;
    logic [15:0] isp_r;
    logic [15:0] sb_r;
    logic [10:0] flags_r;
    logic [10:0] flags_nxt;
    logic ack_r;
    logic [31:0] rdata_r;

    // one-cycle wait on every access, answer on the second edge
    wire acc = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = acc & ~ack_r;
    wire done = acc & ack_r;
    wire wr = avs_write_i & ack_r;
    wire bk = flags_r[`CRS_FLG_B];
    wire [15:0] lo_wd = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'h00,
                         avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00};
    wire [15:0] hi_wd = {avs_byteenable_i[3] ? avs_writedata_i[31:24] : 8'h00,
                         avs_byteenable_i[2] ? avs_writedata_i[23:16] : 8'h00};
    wire [3:0] be = avs_byteenable_i;

    wire [15:0] d0 = data_r[bk][0];
    wire [15:0] d1 = data_r[bk][1];
    wire [15:0] d2 = data_r[bk][2];
    wire [15:0] d3 = data_r[bk][3];
    wire [31:0] wide_d0 = {d2, d0};
    wire [31:0] wide_d1 = {d3, d1};
    wire [31:0] wide_a = {addr_r[bk][1], addr_r[bk][0]};
    wire [15:0] sp_act = flags_r[`CRS_FLG_U] ? usp_r : isp_r;

    // byte-merge helper for a 16-bit register half
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] en);
        merge16 = {en[1] ? nw[15:8] : old[15:8], en[0] ? nw[7:0] : old[7:0]};
    endfunction

    wire sel_d0 = avs_address_i == `CRS_OFF_DATA0;
    wire sel_d1 = avs_address_i == `CRS_OFF_DATA1;
    wire sel_d2 = avs_address_i == `CRS_OFF_DATA2;
    wire sel_d3 = avs_address_i == `CRS_OFF_DATA3;
    wire sel_a0 = avs_address_i == `CRS_OFF_ADDR0;
    wire sel_a1 = avs_address_i == `CRS_OFF_ADDR1;
    wire sel_fb = avs_address_i == `CRS_OFF_FRAME;
    wire sel_vtb = avs_address_i == `CRS_OFF_VTB;
    wire sel_usp = avs_address_i == `CRS_OFF_USP;
    wire sel_isp = avs_address_i == `CRS_OFF_ISP;
    wire sel_sb = avs_address_i == `CRS_OFF_SB;
    wire sel_flg = avs_address_i == `CRS_OFF_FLAGS;
    wire sel_wd0 = avs_address_i == `CRS_OFF_WIDE_D0;
    wire sel_wd1 = avs_address_i == `CRS_OFF_WIDE_D1;
    wire sel_wa = avs_address_i == `CRS_OFF_WIDE_A;

    // read mux; unmapped offsets read zero
    logic [31:0] rmux;
    always_comb begin
        unique case (avs_address_i)
            `CRS_OFF_DATA0: rmux = {16'h0000, d0};
            `CRS_OFF_DATA1: rmux = {16'h0000, d1};
            `CRS_OFF_DATA2: rmux = {16'h0000, d2};
            `CRS_OFF_DATA3: rmux = {16'h0000, d3};
            `CRS_OFF_ADDR0: rmux = {16'h0000, addr_r[bk][0]};
            `CRS_OFF_ADDR1: rmux = {16'h0000, addr_r[bk][1]};
            `CRS_OFF_FRAME: rmux = {16'h0000, frame_r[bk]};
            `CRS_OFF_VTB: rmux = {12'h000, vtb_r};
            `CRS_OFF_PC: rmux = {12'h000, pc_r};
            `CRS_OFF_USP: rmux = {16'h0000, usp_r};
            `CRS_OFF_ISP: rmux = {16'h0000, isp_r};
            `CRS_OFF_SB: rmux = {16'h0000, sb_r};
            `CRS_OFF_FLAGS: rmux = {21'h000000, flags_r};
            `CRS_OFF_WIDE_D0: rmux = wide_d0;
            `CRS_OFF_WIDE_D1: rmux = wide_d1;
            `CRS_OFF_WIDE_A: rmux = wide_a;
            `CRS_OFF_ACT_SP: rmux = {16'h0000, sp_act};
            default: rmux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= acc & ~ack_r;
            if (avs_read_i & ~ack_r) begin
                rdata_r <= rmux;
            end
        end
    end
    assign avs_readdata_o = rdata_r;

    // banked registers, written in the active bank only
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_bank
            wire act = (bk == g[0]) & wr;
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    data_r[g] <= '{default: 16'h0000};
                    addr_r[g] <= '{default: 16'h0000};
                    frame_r[g] <= 16'h0000;
                end else if (act) begin
                    // byte lanes let the halves of data0/data1 be written alone
                    if (sel_d0) data_r[g][0] <= merge16(data_r[g][0], lo_wd, be[1:0]);
                    if (sel_d1) data_r[g][1] <= merge16(data_r[g][1], lo_wd, be[1:0]);
                    if (sel_d2) data_r[g][2] <= merge16(data_r[g][2], lo_wd, be[1:0]);
                    if (sel_d3) data_r[g][3] <= merge16(data_r[g][3], lo_wd, be[1:0]);
                    if (sel_wd0) begin
                        data_r[g][0] <= merge16(data_r[g][0], lo_wd, be[1:0]);
                        data_r[g][2] <= merge16(data_r[g][2], hi_wd, be[3:2]);
                    end
                    if (sel_wd1) begin
                        data_r[g][1] <= merge16(data_r[g][1], lo_wd, be[1:0]);
                        data_r[g][3] <= merge16(data_r[g][3], hi_wd, be[3:2]);
                    end
                    if (sel_a0 | sel_wa) addr_r[g][0] <= merge16(addr_r[g][0], lo_wd, be[1:0]);
                    if (sel_a1) addr_r[g][1] <= merge16(addr_r[g][1], lo_wd, be[1:0]);
                    if (sel_wa) addr_r[g][1] <= merge16(addr_r[g][1], hi_wd, be[3:2]);
                    if (sel_fb) frame_r[g] <= merge16(frame_r[g], lo_wd, be[1:0]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vtb_r <= 20'h00000;
            usp_r <= 16'h0000;
            isp_r <= 16'h0000;
            sb_r <= 16'h0000;
        end else if (wr) begin
            if (sel_vtb) vtb_r <= {be[2] ? avs_writedata_i[19:16] : vtb_r[19:16],
                                   merge16(vtb_r[15:0], lo_wd, be[1:0])};
            if (sel_usp) usp_r <= merge16(usp_r, lo_wd, be[1:0]);
            if (sel_isp) isp_r <= merge16(isp_r, lo_wd, be[1:0]);
            if (sel_sb) sb_r <= merge16(sb_r, lo_wd, be[1:0]);
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_r <= `CRS_PC_RST;
        end else if (pc_load_i) begin
            pc_r <= pc_next_i;
        end
    end

    // flag update: software write first, then alu, then acknowledge clears win
    wire swi_low = int_ack_i.sw_int & (int_ack_i.sw_num <= `CRS_SWI_LAST);
    wire any_ack = int_ack_i.hw_ack | int_ack_i.sw_int;
    always_comb begin
        flags_nxt = flags_r;
        if (wr & sel_flg & be[0]) flags_nxt[7:0] = avs_writedata_i[7:0] & `CRS_FLG_MASK_LO;
        if (wr & sel_flg & be[1]) flags_nxt[10:8] = avs_writedata_i[10:8];
        if (alu_flags_i.valid) begin
            flags_nxt[`CRS_FLG_C] = alu_flags_i.carry;
            flags_nxt[`CRS_FLG_Z] = alu_flags_i.zero;
            flags_nxt[`CRS_FLG_S] = alu_flags_i.sign;
            flags_nxt[`CRS_FLG_O] = alu_flags_i.ovf;
        end
        if (any_ack) flags_nxt[`CRS_FLG_I] = 1'b0;
        if (int_ack_i.hw_ack | swi_low) flags_nxt[`CRS_FLG_U] = 1'b0;
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) flags_r <= `CRS_FLG_RST;
        else flags_r <= flags_nxt;
    end

    wire [2:0] cpu_priority_level = flags_r[`CRS_FLG_IPL_HI:`CRS_FLG_IPL_LO];
    assign irq_accept_o = irq_req_i & flags_r[`CRS_FLG_I] & (irq_level_i > cpu_priority_level);

    // address decode over the full 20-bit space
    wire in_sfr = (mem_addr_i <= `CRS_SFR0_HI) |
                  (mem_addr_i >= `CRS_SFR1_LO & mem_addr_i <= `CRS_SFR1_HI);
    wire in_ram = (mem_addr_i >= `CRS_RAM_LO) & (mem_addr_i <= RAM_HI);
    wire in_df = HAS_DFLASH & (mem_addr_i >= `CRS_DF_LO) & (mem_addr_i <= `CRS_DF_HI);
    wire in_vec = (mem_addr_i >= `CRS_VEC_LO) & (mem_addr_i <= `CRS_VEC_HI);
    wire in_rom = (mem_addr_i >= `CRS_ROM_LO) & (mem_addr_i <= ROM_HI);
    always_comb begin
        if (in_sfr) mem_region_o = CRS_REG_SFR;
        else if (in_vec) mem_region_o = CRS_REG_VEC;
        else if (in_ram) mem_region_o = CRS_REG_RAM;
        else if (in_df) mem_region_o = CRS_REG_DFLASH;
        else if (in_rom) mem_region_o = CRS_REG_ROM;
        else mem_region_o = CRS_REG_NONE;
    end

    assign pc_o = pc_r;
    assign active_sp_o = sp_act;
    assign bank_sel_o = bk;

    sequence s_ack_seen;
        int_ack_i.hw_ack;
    endsequence
    a_ack_clears_ie: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_ack_seen |=> !flags_r[`CRS_FLG_I] && !flags_r[`CRS_FLG_U]) else $error("ack left flags set");
    a_zero_flag_alu: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alu_flags_i.valid |=> flags_r[`CRS_FLG_Z] == $past(alu_flags_i.zero)) else $error("zero flag wrong");
    a_carry_flag_alu: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alu_flags_i.valid |=> flags_r[`CRS_FLG_C] == $past(alu_flags_i.carry)) else $error("carry flag wrong");
    a_sign_ovf_flags: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alu_flags_i.valid |=> flags_r[`CRS_FLG_S] == $past(alu_flags_i.sign)
            && flags_r[`CRS_FLG_O] == $past(alu_flags_i.ovf)) else $error("sign or overflow wrong");
    a_accept_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        irq_accept_o |-> irq_level_i > flags_r[10:8]) else $error("low priority accepted");
    a_stack_select: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        active_sp_o == (flags_r[`CRS_FLG_U] ? usp_r : isp_r)) else $error("wrong stack pointer");
    a_vec_region: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_addr_i >= 20'h0FFDC && mem_addr_i <= 20'h0FFFF |-> mem_region_o == CRS_REG_VEC)
        else $error("vector decode wrong");
    a_sfr_region: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_addr_i >= 20'h02C00 && mem_addr_i <= 20'h02FFF |-> mem_region_o == CRS_REG_SFR)
        else $error("peripheral decode wrong");
    a_pc_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        pc_load_i |=> pc_o == $past(pc_next_i)) else $error("pc not loaded");
    a_bus_wait: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait longer than one cycle");
    a_done_answer: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        done |-> !avs_waitrequest_o)
        else $error("answer edge still waiting");

    // flag sources, kept apart so each check names its own trigger
    sequence s_flag_write;
        wr && sel_flg;
    endsequence
    sequence s_no_flag_src;
        !alu_flags_i.valid && !int_ack_i.hw_ack && !int_ack_i.sw_int && !(wr && sel_flg);
    endsequence
    sequence s_sw_low_ack;
        int_ack_i.sw_int && int_ack_i.sw_num <= `CRS_SWI_LAST;
    endsequence
    sequence s_sw_high_ack;
        int_ack_i.sw_int && int_ack_i.sw_num > `CRS_SWI_LAST && !int_ack_i.hw_ack && !(wr && sel_flg);
    endsequence

    a_sw_ack_stack: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_sw_low_ack |=> !flags_r[`CRS_FLG_U] && !flags_r[`CRS_FLG_I])
        else $error("low software ack left flags set");
    a_sw_high_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_sw_high_ack |=> flags_r[`CRS_FLG_U] == $past(flags_r[`CRS_FLG_U]))
        else $error("high software ack changed stack flag");
    a_sw_ack_ie: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        int_ack_i.sw_int |=> !flags_r[`CRS_FLG_I])
        else $error("software ack left irq enable");
    a_flags_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_no_flag_src |=> flags_r == $past(flags_r))
        else $error("flags moved without a source");
    a_debug_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_flag_write |=> !flags_r[`CRS_FLG_D])
        else $error("debug flag written as one");
    a_bank_out: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        bank_sel_o == flags_r[`CRS_FLG_B])
        else $error("bank select output wrong");
    a_alu_bank_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alu_flags_i.valid && !(wr && sel_flg) |=> flags_r[`CRS_FLG_B] == $past(flags_r[`CRS_FLG_B]))
        else $error("alu update moved bank flag");
    a_ovf_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alu_flags_i.valid |=> flags_r[`CRS_FLG_O] == $past(alu_flags_i.ovf))
        else $error("overflow flag wrong");
    a_accept_ie: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        irq_accept_o |-> flags_r[`CRS_FLG_I])
        else $error("irq accepted while disabled");
    a_accept_high: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        irq_req_i && flags_r[`CRS_FLG_I] && irq_level_i > cpu_priority_level |-> irq_accept_o)
        else $error("higher priority refused");

    // wide reads must pair the halves of the bank seen at the request edge
    a_wide_d0_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        avs_read_i && !ack_r && sel_wd0 |=> avs_readdata_o == {$past(d2), $past(d0)})
        else $error("wide data pair 0 wrong");
    a_wide_d1_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        avs_read_i && !ack_r && sel_wd1 |=> avs_readdata_o == {$past(d3), $past(d1)})
        else $error("wide data pair 1 wrong");
    a_wide_a_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        avs_read_i && !ack_r && sel_wa |=> avs_readdata_o == $past(wide_a))
        else $error("wide address pair wrong");
    a_wide_a_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && sel_wa && be == 4'hF |=> addr_r[$past(bk)][1] == $past(avs_writedata_i[31:16]))
        else $error("wide address write lost");
    a_bank_isolate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && sel_d0 |=> data_r[$past(!bk)][0] == $past(data_r[!bk][0]))
        else $error("inactive bank written");
    a_half_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && sel_d0 && be[1:0] == 2'b01 |=> data_r[$past(bk)][0][15:8] == $past(d0[15:8]))
        else $error("upper half disturbed");
    a_usp_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && sel_usp && be[1:0] == 2'b11 |=> usp_r == $past(avs_writedata_i[15:0]))
        else $error("user stack write lost");
    a_sb_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && sel_sb && be[1:0] == 2'b11 |=> sb_r == $past(avs_writedata_i[15:0]))
        else $error("static base write lost");
    a_vtb_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && sel_vtb && be[2:0] == 3'b111 |=> vtb_r == $past(avs_writedata_i[19:0]))
        else $error("vector base write lost");
    a_pc_read_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr && avs_address_i == `CRS_OFF_PC && !pc_load_i |=> pc_r == $past(pc_r))
        else $error("bus write reached pc");

    // decode windows; the ram bound is a parameter, so check against it
    a_df_region: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        HAS_DFLASH && mem_addr_i >= `CRS_DF_LO && mem_addr_i <= `CRS_DF_HI |-> mem_region_o == CRS_REG_DFLASH)
        else $error("data flash decode wrong");
    a_ram_region: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_addr_i >= `CRS_RAM_LO && mem_addr_i <= RAM_HI |-> mem_region_o == CRS_REG_RAM)
        else $error("ram decode wrong");
    a_rom_region: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_addr_i >= `CRS_ROM_LO && mem_addr_i <= ROM_HI && !in_vec |-> mem_region_o == CRS_REG_ROM)
        else $error("program memory decode wrong");
    a_none_region: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_addr_i > ROM_HI && mem_addr_i > `CRS_VEC_HI |-> mem_region_o == CRS_REG_NONE)
        else $error("unmapped space decoded");
    a_sfr_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_addr_i <= `CRS_SFR0_HI |-> mem_region_o == CRS_REG_SFR)
        else $error("low peripheral decode wrong");
endmodule
`default_nettype wire

/* verification/crs_regset_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_regset_tb;
import crs_pkg::*;
logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, pcl = 1'b0, irq = 1'b0, wq, acc, bsel;
logic [7:0] adr = 8'h00;
logic [31:0] wd = 32'h0, q, r, v, cpu_flags;
logic [3:0] be = 4'h0, f;
logic [19:0] pcn = 20'h0, ma = 20'h0, pco;
logic [2:0] lvl = 3'h0;
logic [15:0] asp;
crs_alu_flags_s alu = '0;
crs_int_ack_s ack = '0;
crs_region_e rgn;
int n_errors = 0, compares = 0, cyc = 0, seed = 24404, i;
logic [31:0] m [11];
logic [31:0] m1 [7];
logic [7:0] offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h28, 8'h2C};
logic [5:0] sn [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
logic [19:0] cor [20] = '{20'h00000, 20'h002FF, 20'h00300, 20'h003FF, 20'h00400, 20'h01BFF, 20'h01C00,
    20'h02BFF, 20'h02C00, 20'h02FFF, 20'h03000, 20'h03FFF, 20'h04000, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF,
    20'h10000, 20'h13FFF, 20'h14000, 20'hFFFFF};
crs_regset #(.RAM_HI(20'h01BFF), .ROM_HI(20'h13FFF), .HAS_DFLASH(1'b1)) DUT (
    .clk_sys_i(clk), .resetn_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(q), .avs_waitrequest_o(wq),
    .pc_load_i(pcl), .pc_next_i(pcn), .alu_flags_i(alu), .int_ack_i(ack), .irq_req_i(irq),
    .irq_level_i(lvl), .irq_accept_o(acc), .mem_addr_i(ma), .mem_region_o(rgn), .pc_o(pco),
    .active_sp_o(asp), .bank_sel_o(bsel));
initial begin
    forever #50 clk = ~clk;
end
task automatic summarize;
    $display("checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        n_errors++;
        summarize();
    end
end
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
        n_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
// idle edge first, so a release and the next request never share a time step
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    r = q;
    wr <= 1'b0;
    rd <= 1'b0;
endtask
function automatic logic [2:0] rg(input logic [19:0] a);
    if (a <= 20'h002FF || (a >= 20'h02C00 && a <= 20'h02FFF)) return CRS_REG_SFR;
    if (a >= 20'h0FFDC && a <= 20'h0FFFF) return CRS_REG_VEC;
    if (a >= 20'h00400 && a <= 20'h01BFF) return CRS_REG_RAM;
    if (a >= 20'h03000 && a <= 20'h03FFF) return CRS_REG_DFLASH;
    if (a >= 20'h04000 && a <= 20'h13FFF) return CRS_REG_ROM;
    return CRS_REG_NONE;
endfunction
initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 11; k++) begin
        m[k] = 32'h0;
        bus(1'b0, offs[k], 32'h0, 4'hF);
        chk(r, 32'h0);
    end
    bus(1'b0, 8'h30, 32'h0, 4'hF);
    chk(r, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 30; k++) begin
        i = {$random(seed)} % 11;
        v = $random(seed);
        bus(1'b1, offs[i], v, 4'hF);
        m[i] = v & ((i == 7) ? 32'hFFFFF : 32'hFFFF);
        bus(1'b0, offs[i], 32'h0, 4'hF);
        chk(r, m[i]);
    end
    v = $random(seed);
    bus(1'b1, 8'h00, v, 4'h1);
    m[0][7:0] = v[7:0];
    bus(1'b1, 8'h04, v, 4'h2);
    m[1][15:8] = v[15:8];
    bus(1'b0, 8'h00, 32'h0, 4'hF);
    chk(r, m[0]);
    bus(1'b0, 8'h04, 32'h0, 4'hF);
    chk(r, m[1]);
    bus(1'b0, 8'h34, 32'h0, 4'hF);
    chk(r, {m[2][15:0], m[0][15:0]});
    bus(1'b0, 8'h38, 32'h0, 4'hF);
    chk(r, {m[3][15:0], m[1][15:0]});
    bus(1'b0, 8'h3C, 32'h0, 4'hF);
    chk(r, {m[5][15:0], m[4][15:0]});
    $display("test regs done");
    bus(1'b1, 8'h30, 32'h10, 4'hF);
    @(negedge clk);
    chk({31'h0, bsel}, 32'h1);
    for (int k = 0; k < 7; k++) begin
        m1[k] = $random(seed) & 32'hFFFF;
        bus(1'b1, offs[k], m1[k], 4'hF);
    end
    for (int k = 0; k < 11; k++) begin
        bus(1'b0, offs[k], 32'h0, 4'hF);
        chk(r, (k < 7) ? m1[k] : m[k]);
    end
    bus(1'b1, 8'h30, 32'h0, 4'hF);
    for (int k = 0; k < 7; k++) begin
        bus(1'b0, offs[k], 32'h0, 4'hF);
        chk(r, m[k]);
    end
    $display("test bank done");
    v = $random(seed);
    bus(1'b1, 8'h30, v, 4'hF);
    cpu_flags = v & 32'h7FD;
    bus(1'b0, 8'h30, 32'h0, 4'hF);
    chk(r, cpu_flags);
    chk({31'h0, bsel}, {31'h0, cpu_flags[4]});
    for (int k = 0; k < 6; k++) begin
        f = (k < 2) ? {4{k[0]}} : 4'($random(seed));
        @(posedge clk);
        alu <= {1'b1, f};
        @(posedge clk);
        alu <= '0;
        cpu_flags[0] = f[3];
        cpu_flags[2] = f[2];
        cpu_flags[3] = f[1];
        cpu_flags[5] = f[0];
        bus(1'b0, 8'h30, 32'h0, 4'hF);
        chk(r, cpu_flags);
    end
    for (int k = 0; k < 5; k++) begin
        bus(1'b1, 8'h30, 32'hC0, 4'hF);
        @(posedge clk);
        ack <= (k == 4) ? 8'h80 : {2'b01, sn[k % 4]};
        @(posedge clk);
        ack <= '0;
        bus(1'b0, 8'h30, 32'h0, 4'hF);
        chk(r, (k < 4 && sn[k % 4] > 6'h1F) ? 32'h80 : 32'h0);
    end
    $display("test flags done");
    bus(1'b1, 8'h30, 32'h340, 4'hF);
    for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        irq <= 1'b1;
        lvl <= 3'(k);
        @(negedge clk);
        chk({31'h0, acc}, (k > 3) ? 32'h1 : 32'h0);
    end
    bus(1'b1, 8'h30, 32'h300, 4'hF);
    @(negedge clk);
    chk({31'h0, acc}, 32'h0);
    chk({16'h0, asp}, m[9]);
    bus(1'b1, 8'h30, 32'h80, 4'hF);
    @(negedge clk);
    chk({16'h0, asp}, m[8]);
    bus(1'b1, 8'h40, 32'h1234, 4'hF);
    bus(1'b0, 8'h40, 32'h0, 4'hF);
    chk(r, m[8]);
    $display("test irq done");
    v = $random(seed);
    bus(1'b1, 8'h20, v, 4'hF);
    bus(1'b0, 8'h20, 32'h0, 4'hF);
    chk(r, 32'h0);
    @(posedge clk);
    pcl <= 1'b1;
    pcn <= v[19:0];
    @(posedge clk);
    pcl <= 1'b0;
    @(negedge clk);
    chk({12'h0, pco}, {12'h0, v[19:0]});
    bus(1'b0, 8'h20, 32'h0, 4'hF);
    chk(r, {12'h0, v[19:0]});
    bus(1'b1, 8'hFC, v, 4'hF);
    bus(1'b0, 8'hFC, 32'h0, 4'hF);
    chk(r, 32'h0);
    $display("test pc done");
    for (int k = 0; k < 60; k++) begin
        @(posedge clk);
        ma <= (k < 20) ? cor[k] : 20'($random(seed)) & 20'h1FFFF;
        @(negedge clk);
        chk({29'h0, rgn}, {29'h0, rg(ma)});
    end
    $display("test decode done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h30, 32'h0, 4'hF);
    chk(r, 32'h0);
    chk({31'h0, bsel}, 32'h0);
    $display("test rereset done");
    summarize();
end
endmodule
`default_nettype wire
